// *** verilog/msq_pkg.sv ***
// Shared constants, microword field layout and address modification.
// Assumes one processor clock; modules import the whole package, the store interface uses scoped names.
package msq_pkg;

    localparam int MW_W = 57;
    localparam int ROM_DEPTH = 256;
    localparam int AW = 8;
    localparam int IR_W = 16;
    localparam int FLAG_W = 4;
    localparam int EXT_W = 8;

    localparam int NXT_LSB = 0;
    localparam int NXT_MSB = 7;
    localparam int RSV_BIT = 8;
    localparam int CTL_LSB = 9;
    localparam int CTL_MSB = 56;
    localparam int CTL_W = CTL_MSB - CTL_LSB + 1;
    localparam int BR_LSB = 17;
    localparam int BR_MSB = 21;
    localparam int STOP_BIT = 54;
    localparam int LEN_LO_BIT = 55;
    localparam int LEN_HI_BIT = 56;

    localparam logic [AW-1:0] RESET_ENTRY = 8'h00;

    // Last tick index of a processor cycle for each length choice
    localparam logic [1:0] CYC_LAST_SHORT = 2'h0;
    localparam logic [1:0] CYC_LAST_MID = 2'h1;
    localparam logic [1:0] CYC_LAST_LONG = 2'h2;

    // Branch test codes; codes above BR_ENTRY mean no branch
    localparam logic [4:0] BR_NONE = 5'h00;
    localparam logic [4:0] BR_FLAG0 = 5'h01;
    localparam logic [4:0] BR_FLAG3 = 5'h04;
    localparam logic [4:0] BR_EXT0 = 5'h05;
    localparam logic [4:0] BR_EXT7 = 5'h0c;
    localparam logic [4:0] BR_IR_OP = 5'h0d;
    localparam logic [4:0] BR_ENTRY = 5'h0e;

    // Start of the microroutine group for a fetched instruction
    function automatic logic [AW-1:0] msq_entry(input logic [IR_W-1:0] ir);
        return {ir[15:12], ir[5:3], 1'b0};
    endfunction

    function automatic logic msq_cond(
        input logic [4:0] sel,
        input logic [FLAG_W-1:0] flags,
        input logic [EXT_W-1:0] ext
    );
        logic [4:0] fi;
        logic [4:0] ei;
        fi = sel - BR_FLAG0;
        ei = sel - BR_EXT0;
        if (sel >= BR_FLAG0 && sel <= BR_FLAG3)
            return flags[fi[1:0]];
        else if (sel >= BR_EXT0 && sel <= BR_EXT7)
            return ext[ei[2:0]];
        else
            return 1'b0;
    endfunction

    function automatic logic [AW-1:0] msq_modify(
        input logic [4:0] sel,
        input logic [AW-1:0] base,
        input logic [FLAG_W-1:0] flags,
        input logic [EXT_W-1:0] ext,
        input logic [IR_W-1:0] ir
    );
        if (sel == BR_ENTRY)
            return msq_entry(ir);
        else if (sel == BR_IR_OP)
            return base | {4'h0, ir[15:12]};
        else if (msq_cond(sel, flags, ext))
            return base | 8'h01;
        else
            return base;
    endfunction

endpackage

// *** verilog/msq_store_if.sv ***
// Carrier between the sequencer and its control store.
// Read is combinational from the address; writes load microcode.
`timescale 1ns/10ps
interface msq_store_if;
    logic [msq_pkg::AW-1:0] rd_addr;
    logic [msq_pkg::MW_W-1:0] rd_data;
    logic wr_en;
    logic [msq_pkg::AW-1:0] wr_addr;
    logic [msq_pkg::MW_W-1:0] wr_data;
    modport seq (output rd_addr, output wr_en, output wr_addr,
        output wr_data, input rd_data);
    modport store (input rd_addr, input wr_en, input wr_addr,
        input wr_data, output rd_data);
endinterface

// *** verilog/msq_store.sv ***
// Control store: 256 microwords, one per machine state.
// Assumes microcode is loaded through the write side before use.
`timescale 1ns/10ps
module msq_store (
    input wire logic clk,
    msq_store_if.store st
);
    import msq_pkg::*;

    // Same layout in every word; no address-dependent decode
    logic [MW_W-1:0] mem [ROM_DEPTH];

    always_ff @(posedge clk)
    begin
        if (st.wr_en)
            mem[st.wr_addr] <= st.wr_data;
    end

    // Asynchronous read so the buffer captures the word in the same cycle
    assign st.rd_data = mem[st.rd_addr];
endmodule

// *** verilog/msq_sequencer.sv ***
// Microprogram sequencer: microaddress register, microword buffer,
// branch modification and cycle-length timing.
// Assumes ir and flags come from same-clock datapath logic; ext_cond and
// restart are external and are synchronised here.
//
// Contract
// - Control store holds 256 microwords of the full field width.
// - Each processor cycle one microword is read and latched.
// - Bits 07:00 hold the next microword address.
// - Bits 56:09 are control bits driven straight onto control lines.
// - Bit 08 is reserved for extended addressing and otherwise unused.
// - Stored control bits are the control signals without extra decoding.
// - Buffered word controls the machine while the next word is fetched.
// - Microaddress changes on every processor clock pulse.
// - Without a branch the next-address field is used unmodified.
// - Branch modification acts on the address before it is registered.
// - Loaded address is fixed; branch in word N alters word N+2.
// - Test field picks the condition; a taken branch alters the address.
// - Testable conditions: instruction register, flags, other conditions.
// - Instruction register decodes to its microroutine entry address.
// - All microwords share one field layout.
// - Bits 21:17 select the branch condition.
// - Bit 54 set stops the processor clock.
// - Bits 56:55 choose one of three processor cycle lengths.
`timescale 1ns/10ps
module msq_sequencer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [msq_pkg::IR_W-1:0] instruction_register,
    input wire logic [msq_pkg::FLAG_W-1:0] flags,
    input wire logic [msq_pkg::EXT_W-1:0] ext_cond,
    input wire logic restart,
    input wire logic load_en,
    input wire logic [msq_pkg::AW-1:0] load_addr,
    input wire logic [msq_pkg::MW_W-1:0] load_data,
    output logic [msq_pkg::AW-1:0] microaddress_register,
    output logic [msq_pkg::CTL_W-1:0] control_lines,
    output logic clock_stop_bit,
    output logic cycle_end
);
    import msq_pkg::*;

    logic [MW_W-1:0] uword;
    logic [MW_W-1:0] next_uword;
    logic [AW-1:0] microprogram_pointer;
    logic [AW-1:0] next_upp;
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic next_cycle_end;
    logic [EXT_W-1:0] ext_meta;
    logic [EXT_W-1:0] ext_s;
    logic restart_meta;
    logic restart_s;
    logic [1:0] last;
    logic hold;
    logic adv;
    logic [4:0] branch_micro_test;

    msq_store_if st ();

    msq_store u_store (
        .clk (clk),
        .st (st)
    );

    assign st.rd_addr = microprogram_pointer;
    assign st.wr_en = load_en;
    assign st.wr_addr = load_addr;
    assign st.wr_data = load_data;

    // External levels pass two flops before anything looks at them
    always_ff @(posedge clk)
    begin
        ext_meta <= ext_cond;
        ext_s <= ext_meta;
        restart_meta <= restart;
        restart_s <= restart_meta;
    end

    assign branch_micro_test = uword[BR_MSB:BR_LSB];

    // Cycle length from the buffered word: 1, 2 or 3 clock ticks
    always_comb
    begin
        if (uword[LEN_HI_BIT])
            last = CYC_LAST_LONG;
        else if (uword[LEN_LO_BIT])
            last = CYC_LAST_MID;
        else
            last = CYC_LAST_SHORT;
    end

    // Stop holds the cycle open until restart is seen
    assign hold = uword[STOP_BIT] && !restart_s;
    assign adv = (cnt == last) && !hold;

    always_comb
    begin
        next_uword = uword;
        next_upp = microprogram_pointer;
        next_cnt = cnt;
        next_cycle_end = adv;
        if (sys_rst)
        begin
            next_uword = '0;
            next_upp = RESET_ENTRY;
            next_cnt = 2'h0;
            next_cycle_end = 1'b0;
        end
        else if (adv)
        begin
            // Buffer takes word N+1 while its own next field, the
            // address of N+2, is steered by the test of word N.
            next_uword = st.rd_data;
            // Only bits 07:00 feed the address; bit 08 stays reserved
            next_upp = msq_modify(branch_micro_test,
                st.rd_data[NXT_MSB:NXT_LSB],
                flags, ext_s, instruction_register);
            next_cnt = 2'h0;
        end
        else if (cnt != last)
            next_cnt = cnt + 2'h1;
    end

    always_ff @(posedge clk)
    begin
        uword <= next_uword;
        microprogram_pointer <= next_upp;
        cnt <= next_cnt;
        cycle_end <= next_cycle_end;
    end

    assign microaddress_register = microprogram_pointer;
    // Stored bits are the control lines; no decode in between
    assign control_lines = uword[CTL_MSB:CTL_LSB];
    assign clock_stop_bit = uword[STOP_BIT];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_long_wait;
        !adv ##1 !adv;
    endsequence

    sequence s_stop_held;
        hold [*3];
    endsequence

    a_reset_entry: assert property (
        disable iff (1'b0)
        sys_rst |=> (microprogram_pointer == RESET_ENTRY) && (uword == '0))
        else $error("reset did not load entry address and clear buffer");

    a_buffer_load: assert property (
        adv |=> uword == $past(st.rd_data))
        else $error("buffer did not latch the fetched microword");

    a_addr_hold: assert property (
        !adv |=> $stable(microprogram_pointer) && $stable(uword))
        else $error("address or buffer changed inside a cycle");

    a_seq_plain: assert property (
        adv && branch_micro_test == BR_NONE
        |=> microprogram_pointer == $past(st.rd_data[NXT_MSB:NXT_LSB]))
        else $error("unbranched next address was modified");

    a_branch_flag: assert property (
        adv && branch_micro_test >= BR_FLAG0
        && branch_micro_test <= BR_FLAG3
        && flags[branch_micro_test[1:0] - 2'h1]
        |=> microprogram_pointer[0] == 1'b1)
        else $error("taken flag branch did not alter the address");

    a_entry_decode: assert property (
        adv && branch_micro_test == BR_ENTRY
        |=> microprogram_pointer == msq_entry($past(instruction_register)))
        else $error("instruction entry address is wrong");

    a_ctrl_direct: assert property (
        adv |=> control_lines == $past(st.rd_data[CTL_MSB:CTL_LSB])
        && clock_stop_bit == $past(st.rd_data[STOP_BIT]))
        else $error("control lines differ from the fetched control bits");

    a_stop_hold: assert property (
        s_stop_held |-> !adv && $stable(microprogram_pointer))
        else $error("sequencer advanced while stopped");

    a_cycle_long: assert property (
        cnt == 2'h0 && uword[LEN_HI_BIT]
        |-> s_long_wait ##1 (adv || hold))
        else $error("long cycle length is wrong");

    a_cycle_short: assert property (
        !uword[LEN_HI_BIT] && !uword[LEN_LO_BIT] && !uword[STOP_BIT]
        |-> adv ##1 cycle_end)
        else $error("short cycle did not advance every tick");

    a_ext_branch: assert property (
        adv && branch_micro_test >= BR_EXT0
        && branch_micro_test <= BR_EXT7
        && ext_s[3'(branch_micro_test - BR_EXT0)]
        |=> microprogram_pointer[0] == 1'b1)
        else $error("taken external branch did not alter the address");

    a_ir_branch: assert property (
        adv && branch_micro_test == BR_IR_OP
        |=> microprogram_pointer == ($past(st.rd_data[NXT_MSB:NXT_LSB])
        | {4'h0, $past(instruction_register[15:12])}))
        else $error("opcode branch did not merge into the address");

    a_no_branch_hi: assert property (
        adv && branch_micro_test > BR_ENTRY
        |=> microprogram_pointer == $past(st.rd_data[NXT_MSB:NXT_LSB]))
        else $error("unused test code altered the address");

    a_cycle_mid: assert property (
        cnt == 2'h0 && !uword[LEN_HI_BIT] && uword[LEN_LO_BIT]
        |-> !adv ##1 (adv || hold))
        else $error("middle cycle length is wrong");

    // Counter parks on its last tick, so a stop cannot stretch it further
    a_count_bound: assert property (
        cnt <= last)
        else $error("cycle counter passed its last tick");

    a_end_pulse: assert property (
        adv |=> cycle_end)
        else $error("cycle end missing after an advance");

    a_end_quiet: assert property (
        !adv |=> !cycle_end)
        else $error("cycle end raised without an advance");
endmodule

// *** sim/msq_dp_model.sv ***
// Datapath stand-in: drives instruction, flags and external conditions.
// Assumes shuffle is raised only while the sequencer is stopped, so the
// new values settle well past the two-flop latency of the conditions.
`timescale 1ns/10ps
module msq_dp_model (
    input wire logic clk,
    input wire logic shuffle,
    output logic [msq_pkg::IR_W-1:0] ir,
    output logic [msq_pkg::FLAG_W-1:0] fl,
    output logic [msq_pkg::EXT_W-1:0] ext
);
    import msq_pkg::*;
    // One process owns each value; a known start keeps branches defined
    logic [IR_W-1:0] ir_q = '0;
    logic [FLAG_W-1:0] fl_q = '0;
    logic [EXT_W-1:0] ext_q = '0;
    assign ir = ir_q;
    assign fl = fl_q;
    assign ext = ext_q;
    always @(negedge clk)
    begin
        if (shuffle)
        begin
            ir_q <= IR_W'($urandom);
            fl_q <= FLAG_W'($urandom);
            ext_q <= EXT_W'($urandom);
        end
    end
endmodule

// *** sim/msq_sequencer_tb.sv ***
// Self-checking bench for the sequencer with a random microprogram.
// Assumes the store is loaded while sys_rst is high.
`timescale 1ns/10ps
module msq_sequencer_tb;
    import msq_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic restart = 1'b0;
    logic shuffle = 1'b0;
    logic load_en = 1'b0;
    logic [AW-1:0] load_addr = '0;
    logic [MW_W-1:0] load_data = '0;
    logic [IR_W-1:0] ir;
    logic [FLAG_W-1:0] fl;
    logic [EXT_W-1:0] ext;
    logic [AW-1:0] microprogram_pointer;
    logic [CTL_W-1:0] ctl;
    logic stop;
    logic cend;
    logic [MW_W-1:0] mem [ROM_DEPTH];
    logic [MW_W-1:0] e_buf;
    logic [AW-1:0] e_upp;
    int error_cnt = 0;
    int compares = 0;
    int gap;
    logic hung = 1'b0;

    always #2 clk = ~clk;

    msq_dp_model msq_dp_model_inst (.clk(clk), .shuffle(shuffle),
        .ir(ir), .fl(fl), .ext(ext));
    msq_sequencer msq_sequencer_inst (.clk(clk), .sys_rst(sys_rst),
        .instruction_register(ir), .flags(fl), .ext_cond(ext),
        .restart(restart), .load_en(load_en), .load_addr(load_addr),
        .load_data(load_data), .microaddress_register(microprogram_pointer),
        .control_lines(ctl), .clock_stop_bit(stop), .cycle_end(cend));

    task automatic print_verdict;
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Independent reading of the branch codes
    function automatic logic [AW-1:0] ref_next(input logic [4:0] s,
        input logic [AW-1:0] b);
        if (s >= 5'h01 && s <= 5'h04)
            return b | {7'h00, fl[s - 5'h01]};
        if (s >= 5'h05 && s <= 5'h0c)
            return b | {7'h00, ext[s - 5'h05]};
        if (s == 5'h0d)
            return b | {4'h0, ir[15:12]};
        if (s == 5'h0e)
            return {ir[15:12], ir[5:3], 1'b0};
        return b;
    endfunction

    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (20) @(negedge clk);
        check(microprogram_pointer, RESET_ENTRY);
        check({stop, cend, ctl}, 64'h0);
        e_upp = RESET_ENTRY;
        e_buf = '0;
    endtask

    task automatic run(input int n);
        int len;
        logic [MW_W-1:0] nb;
        repeat (n)
        begin
            len = e_buf[LEN_HI_BIT] ? 3 : (e_buf[LEN_LO_BIT] ? 2 : 1);
            if (e_buf[STOP_BIT])
            begin
                shuffle <= 1'b1;
                repeat (10)
                begin
                    @(negedge clk);
                    shuffle <= 1'b0;
                    check(cend, 1'b0);
                end
                restart <= 1'b1;
                @(negedge clk);
                restart <= 1'b0;
            end
            gap = 0;
            do
            begin
                @(negedge clk);
                gap++;
            end while (cend !== 1'b1 && gap < 40);
            if (gap >= 40)
            begin
                error_cnt++;
                hung = 1'b1;
                return;
            end
            if (!e_buf[STOP_BIT])
                check(gap, len);
            nb = mem[e_upp];
            // Branch field of the word that was executing alters N+2
            e_upp = ref_next(e_buf[BR_MSB:BR_LSB], nb[NXT_MSB:NXT_LSB]);
            e_buf = nb;
            check(microprogram_pointer, e_upp);
            check(ctl, e_buf[CTL_MSB:CTL_LSB]);
            check(stop, e_buf[STOP_BIT]);
        end
    endtask

    initial
    begin
        logic [MW_W-1:0] w;
        void'($urandom(32'he019));
        @(negedge clk);
        do_reset();
        // Every branch code appears; bit 08 stays random to prove it unused
        for (int i = 0; i < ROM_DEPTH; i++)
        begin
            w = MW_W'({$urandom, $urandom});
            w[BR_MSB:BR_LSB] = i[4:0];
            w[STOP_BIT] = (i[2:0] == 3'h3);
            if (i == 0)
                w[NXT_MSB:NXT_LSB] = 8'hff;
            mem[i] = w;
            load_en <= 1'b1;
            load_addr <= i[AW-1:0];
            load_data <= w;
            @(negedge clk);
        end
        load_en <= 1'b0;
        sys_rst <= 1'b0;
        run(600);
        if (!hung)
        begin
            do_reset();
            sys_rst <= 1'b0;
            run(200);
        end
        print_verdict();
    end
endmodule
